// >>> src/otc_defines.vh
// constants for the output terminal conditioner
`ifndef OTC_DEFINES_VH
`define OTC_DEFINES_VH
// ----------------------------------------------------------------------
// register byte offsets (apb, one aligned word each)
// ----------------------------------------------------------------------
`define OTC_ADDR_PULSE_SRC 8'h00
`define OTC_ADDR_AO1_SRC 8'h04
`define OTC_ADDR_AO2_SRC 8'h08
`define OTC_ADDR_PULSE_FS 8'h0c
`define OTC_ADDR_AO1_OFS 8'h10
`define OTC_ADDR_AO1_GAIN 8'h14
`define OTC_ADDR_AO2_OFS 8'h18
`define OTC_ADDR_AO2_GAIN 8'h1c
`define OTC_ADDR_DLY_PULSE 8'h20
`define OTC_ADDR_DLY_C1 8'h24
`define OTC_ADDR_DLY_C2 8'h28
`define OTC_ADDR_DLY_SW2 8'h2c
`define OTC_ADDR_POLARITY 8'h30
`define OTC_ADDR_STATUS 8'h34
`define OTC_ADDR_AO1_VAL 8'h38
`define OTC_ADDR_AO2_VAL 8'h3c
// ----------------------------------------------------------------------
// reset values and ranges (units: 0.01 khz, 0.1 %, 0.01 gain, 0.1 s)
// ----------------------------------------------------------------------
`define OTC_RST_PULSE_SRC 4'h0
`define OTC_RST_AO1_SRC 4'h0
`define OTC_RST_AO2_SRC 4'h1
`define OTC_RST_PULSE_FS 14'h1388
`define OTC_MIN_PULSE_FS 14'h0001
`define OTC_MAX_PULSE_FS 14'h2710
`define OTC_RST_GAIN 16'h0064
`define OTC_MAX_GAIN 16'h03e8
`define OTC_MAX_OFS 16'h03e8
`define OTC_MAX_DELAY 16'h8ca0
`define OTC_RST_POLARITY 17'h00000
`define OTC_MAX_POLARITY 17'h1869f
// full scale of an output value: 1000 = 100.0 %
`define OTC_FULL_SCALE 16'h03e8
// ----------------------------------------------------------------------
// source codes
// ----------------------------------------------------------------------
`define OTC_SRC_RUN_FREQ 4'h0
`define OTC_SRC_SET_FREQ 4'h1
`define OTC_SRC_CURRENT 4'h2
`define OTC_SRC_TORQUE 4'h3
`define OTC_SRC_POWER 4'h4
`define OTC_SRC_VOLTAGE 4'h5
// ----------------------------------------------------------------------
// timing: clock and tick periods
// ----------------------------------------------------------------------
`define OTC_CLK_HZ 250000000
`define OTC_DELAY_TICK_S_DIV 10
`define OTC_DELAY_TICK_CYC (`OTC_CLK_HZ / `OTC_DELAY_TICK_S_DIV)
`endif

// >>> src/otc_delay_out.v
// delayed, polarity-adjusted drive of one switched terminal
`timescale 1ns/1ns
module otc_delay_out #(
  parameter CNT_W = 16 // width of the delay counter in 0.1 s ticks
) (
  input wire i_ref_clk, // system clock
  input wire i_resetn, // async reset, active low
  input wire i_tick, // one-cycle pulse every 0.1 s
  input wire i_status, // internal function status
  input wire [CNT_W-1:0] i_delay, // delay in 0.1 s units
  input wire i_negative, // polarity digit value
  output reg o_close // 1 = terminal closed to common return
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg applied_r; // status currently shown at the terminal
  reg [CNT_W-1:0] cnt_r; // elapsed ticks since the pending change
  // ----------------------------------------------------------------------
  // delay: a change must persist for the full delay; a glitch shorter
  // than the delay restarts the wait instead of being shown late
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      applied_r <= 1'b0;
      cnt_r <= {CNT_W{1'b0}};
      o_close <= 1'b0;
    end else begin
      if (i_status == applied_r) begin
        cnt_r <= {CNT_W{1'b0}};
      end else if (cnt_r >= i_delay) begin
        applied_r <= i_status;
        cnt_r <= {CNT_W{1'b0}};
      end else if (i_tick) begin
        cnt_r <= cnt_r + 1'b1;
      end
      // polarity 0 closes while active, 1 opens while active
      o_close <= applied_r ^ i_negative;
    end
  end
endmodule // otc_delay_out

// >>> src/otc_nco.v
// pulse-train generator by phase accumulation
`timescale 1ns/1ns
module otc_nco #(
  parameter ACC_W = 32 // phase accumulator width
) (
  input wire i_ref_clk, // system clock
  input wire i_resetn, // async reset, active low
  input wire [ACC_W-1:0] i_step, // phase step per clock
  output reg o_pulse // square wave out
);
  reg [ACC_W-1:0] acc_r; // phase accumulator
  // ----------------------------------------------------------------------
  // msb of the accumulator is a 50 % duty square wave
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_r <= {ACC_W{1'b0}};
      o_pulse <= 1'b0;
    end else begin
      acc_r <= acc_r + i_step;
      o_pulse <= acc_r[ACC_W-1];
    end
  end
endmodule // otc_nco

// >>> src/otc_top.v
// output terminal conditioner: pulse, analog and switched outputs
//
// Function
// - pulse frequency from 0.01 khz up to full-scale
// - full-scale setting 0.01..100 khz, default 50
// - codes 0,1 full scale at max frequency
// - codes 2,3 full scale at twice rated
// - code 5 full scale at 1.2 rated voltage
// - analog out equals gain times standard plus offset
// - offset +-100 %, gain +-10, defaults 0, 1
// - 100 % offset equals full 10 v / 20 ma
// - standard output is unadjusted source mapping
// - both channels span 0..100 % range
// - each switch output except the digital output delayed 0..3600 s
// - five polarity digits, default 00000
// - digit 0 closes terminal while active
// - digit 1 opens terminal while active
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
`include "otc_defines.vh"
module otc_top #(
  parameter TICK_CYC = `OTC_DELAY_TICK_CYC, // cycles per 0.1 s
  parameter Q_W = 16 // width of source quantities
) (
  input wire i_ref_clk, // system clock 250 mhz
  input wire i_resetn, // async reset, active low
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire i_pwrite, // apb direction
  input wire [7:0] i_paddr, // apb byte address
  input wire [31:0] i_pwdata, // apb write data
  output reg [31:0] o_prdata, // apb read data
  output reg o_pready, // apb ready
  output reg o_pslverr, // apb error on unmapped address
  input wire [Q_W-1:0] i_run_freq, // running frequency
  input wire [Q_W-1:0] i_set_freq, // set frequency
  input wire [Q_W-1:0] i_max_freq, // maximum output frequency
  input wire [Q_W-1:0] i_current, // output current
  input wire [Q_W-1:0] i_rated_current, // rated motor current
  input wire [Q_W-1:0] i_torque, // absolute torque
  input wire [Q_W-1:0] i_rated_torque, // rated motor torque
  input wire [Q_W-1:0] i_power, // output power
  input wire [Q_W-1:0] i_rated_power, // rated power
  input wire [Q_W-1:0] i_voltage, // output voltage
  input wire [Q_W-1:0] i_rated_voltage, // rated drive voltage
  input wire [Q_W-1:0] i_other_pct, // other codes, 0.1 % units
  input wire [4:0] i_func_status, // switched function states
  input wire i_pulse_mode, // 1 = pulse_capable_output as pulse
  output reg o_pulse_capable_output, // pulse or switch terminal
  output reg o_contact_output_one, // relay one closed
  output reg o_contact_output_two, // relay two closed
  output reg o_second_switch_output, // second switch closed
  output reg o_digital_output, // digital output closed
  output reg [9:0] o_analog_out_one, // 0..1000 = 0..100 %
  output reg [9:0] o_analog_out_two // 0..1000 = 0..100 %
);
  localparam TICK_W = 32; // tick counter width
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // scale q against a reference to 0..1000, clamped
  function [15:0] otc_pct;
    input [Q_W-1:0] q;
    input [Q_W+3:0] ref_q;
    reg [Q_W+13:0] num;
    reg [Q_W+13:0] quo; // full-width quotient, at most 1000
    begin
      num = {14'h0000, q} * 10'd1000;
      if (ref_q == {(Q_W+4){1'b0}}) begin
        otc_pct = 16'h0000;
      end else if (num >= ref_q * `OTC_FULL_SCALE) begin
        otc_pct = `OTC_FULL_SCALE;
      end else begin
        quo = num / ref_q;
        otc_pct = quo[15:0];
      end
    end
  endfunction
  // source select to standard output 0..1000
  function [15:0] otc_src;
    input [3:0] sel;
    input [Q_W+3:0] max_f;
    input [Q_W+3:0] cur2;
    input [Q_W+3:0] trq2;
    input [Q_W+3:0] pwr2;
    input [Q_W+3:0] vlt12;
    begin
      case (sel)
        `OTC_SRC_RUN_FREQ: otc_src = otc_pct(i_run_freq, max_f);
        `OTC_SRC_SET_FREQ: otc_src = otc_pct(i_set_freq, max_f);
        `OTC_SRC_CURRENT: otc_src = otc_pct(i_current, cur2);
        `OTC_SRC_TORQUE: otc_src = otc_pct(i_torque, trq2);
        `OTC_SRC_POWER: otc_src = otc_pct(i_power, pwr2);
        `OTC_SRC_VOLTAGE: otc_src = otc_pct(i_voltage, vlt12);
        default: otc_src = (i_other_pct > `OTC_FULL_SCALE) ?
          `OTC_FULL_SCALE : i_other_pct;
      endcase
    end
  endfunction
  // y = k*x + b in 0.1 % units, gain in 0.01, clamped
  function [9:0] otc_adjust;
    input [15:0] x;
    input [15:0] gain;
    input [15:0] ofs;
    reg signed [35:0] y;
    begin
      y = ($signed({20'h00000, x}) * $signed({{20{gain[15]}}, gain}))
        / 36'sd100 + $signed({{20{ofs[15]}}, ofs});
      if (y < 36'sd0) begin
        otc_adjust = 10'h000;
      end else if (y > 36'sd1000) begin
        otc_adjust = 10'h3e8;
      end else begin
        otc_adjust = y[9:0];
      end
    end
  endfunction
  // limit a signed setting to +-lim
  function [15:0] otc_sclamp;
    input [15:0] v;
    input [15:0] lim;
    begin
      if (!v[15] && v > lim) begin
        otc_sclamp = lim;
      end else if (v[15] && (16'h0000 - v) > lim) begin
        otc_sclamp = 16'h0000 - lim;
      end else begin
        otc_sclamp = v;
      end
    end
  endfunction
  // ----------------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------------
  reg [3:0] pulse_source_select_r; // pulse source code
  reg [3:0] analog_one_source_select_r; // channel one source code
  reg [3:0] analog_two_source_select_r; // channel two source code
  reg [13:0] pulse_full_scale_freq_r; // 0.01 khz units
  reg [15:0] analog_one_zero_offset_r; // signed 0.1 %
  reg [15:0] analog_one_gain_r; // signed 0.01
  reg [15:0] analog_two_zero_offset_r; // signed 0.1 %
  reg [15:0] analog_two_gain_r; // signed 0.01
  reg [15:0] delay_r [0:3]; // delays: pulse, c1, c2, second switch
  reg [16:0] output_polarity_digits_r; // decimal 00000..99999
  // ----------------------------------------------------------------------
  // apb slave: one wait state, ready registered after the access cycle
  // ----------------------------------------------------------------------
  wire acc = i_psel & i_penable & ~o_pready; // one access per transfer
  wire [15:0] wd16 = i_pwdata[15:0];
  reg [31:0] rd_nxt; // read mux
  reg hit_nxt; // address is mapped
  always @* begin
    hit_nxt = 1'b1;
    case (i_paddr)
      `OTC_ADDR_PULSE_SRC: rd_nxt = {28'h0000000, pulse_source_select_r};
      `OTC_ADDR_AO1_SRC: rd_nxt = {28'h0000000, analog_one_source_select_r};
      `OTC_ADDR_AO2_SRC: rd_nxt = {28'h0000000, analog_two_source_select_r};
      `OTC_ADDR_PULSE_FS: rd_nxt = {18'h00000, pulse_full_scale_freq_r};
      `OTC_ADDR_AO1_OFS: rd_nxt = {16'h0000, analog_one_zero_offset_r};
      `OTC_ADDR_AO1_GAIN: rd_nxt = {16'h0000, analog_one_gain_r};
      `OTC_ADDR_AO2_OFS: rd_nxt = {16'h0000, analog_two_zero_offset_r};
      `OTC_ADDR_AO2_GAIN: rd_nxt = {16'h0000, analog_two_gain_r};
      `OTC_ADDR_DLY_PULSE: rd_nxt = {16'h0000, delay_r[0]};
      `OTC_ADDR_DLY_C1: rd_nxt = {16'h0000, delay_r[1]};
      `OTC_ADDR_DLY_C2: rd_nxt = {16'h0000, delay_r[2]};
      `OTC_ADDR_DLY_SW2: rd_nxt = {16'h0000, delay_r[3]};
      `OTC_ADDR_POLARITY: rd_nxt = {15'h0000, output_polarity_digits_r};
      `OTC_ADDR_STATUS: rd_nxt = {27'h0000000, o_digital_output,
        o_second_switch_output, o_contact_output_two,
        o_contact_output_one, o_pulse_capable_output};
      `OTC_ADDR_AO1_VAL: rd_nxt = {22'h000000, o_analog_out_one};
      `OTC_ADDR_AO2_VAL: rd_nxt = {22'h000000, o_analog_out_two};
      default: begin
        rd_nxt = 32'h00000000;
        hit_nxt = 1'b0;
      end
    endcase
  end
  // register writes; out-of-range values are limited, not wrapped; an out-of-range polarity write is ignored
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pulse_source_select_r <= `OTC_RST_PULSE_SRC;
      analog_one_source_select_r <= `OTC_RST_AO1_SRC;
      analog_two_source_select_r <= `OTC_RST_AO2_SRC;
      pulse_full_scale_freq_r <= `OTC_RST_PULSE_FS;
      analog_one_zero_offset_r <= 16'h0000;
      analog_one_gain_r <= `OTC_RST_GAIN;
      analog_two_zero_offset_r <= 16'h0000;
      analog_two_gain_r <= `OTC_RST_GAIN;
      delay_r[0] <= 16'h0000;
      delay_r[1] <= 16'h0000;
      delay_r[2] <= 16'h0000;
      delay_r[3] <= 16'h0000;
      output_polarity_digits_r <= `OTC_RST_POLARITY;
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= acc;
      o_pslverr <= acc & ~hit_nxt;
      o_prdata <= (acc & ~i_pwrite) ? rd_nxt : 32'h00000000;
      if (acc && i_pwrite) begin
        case (i_paddr)
          `OTC_ADDR_PULSE_SRC: pulse_source_select_r <= i_pwdata[3:0];
          `OTC_ADDR_AO1_SRC: analog_one_source_select_r <= i_pwdata[3:0];
          `OTC_ADDR_AO2_SRC: analog_two_source_select_r <= i_pwdata[3:0];
          `OTC_ADDR_PULSE_FS: begin
            if (wd16 < {2'b00, `OTC_MIN_PULSE_FS}) begin
              pulse_full_scale_freq_r <= `OTC_MIN_PULSE_FS;
            end else if (wd16 > {2'b00, `OTC_MAX_PULSE_FS}) begin
              pulse_full_scale_freq_r <= `OTC_MAX_PULSE_FS;
            end else begin
              pulse_full_scale_freq_r <= wd16[13:0];
            end
          end
          `OTC_ADDR_AO1_OFS:
            analog_one_zero_offset_r <= otc_sclamp(wd16, `OTC_MAX_OFS);
          `OTC_ADDR_AO1_GAIN:
            analog_one_gain_r <= otc_sclamp(wd16, `OTC_MAX_GAIN);
          `OTC_ADDR_AO2_OFS:
            analog_two_zero_offset_r <= otc_sclamp(wd16, `OTC_MAX_OFS);
          `OTC_ADDR_AO2_GAIN:
            analog_two_gain_r <= otc_sclamp(wd16, `OTC_MAX_GAIN);
          `OTC_ADDR_DLY_PULSE: delay_r[0] <=
            (wd16 > `OTC_MAX_DELAY) ? `OTC_MAX_DELAY : wd16;
          `OTC_ADDR_DLY_C1: delay_r[1] <=
            (wd16 > `OTC_MAX_DELAY) ? `OTC_MAX_DELAY : wd16;
          `OTC_ADDR_DLY_C2: delay_r[2] <=
            (wd16 > `OTC_MAX_DELAY) ? `OTC_MAX_DELAY : wd16;
          `OTC_ADDR_DLY_SW2: delay_r[3] <=
            (wd16 > `OTC_MAX_DELAY) ? `OTC_MAX_DELAY : wd16;
          `OTC_ADDR_POLARITY: begin
            if (i_pwdata[16:0] <= `OTC_MAX_POLARITY) begin
              output_polarity_digits_r <= i_pwdata[16:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  // ----------------------------------------------------------------------
  // polarity digits: units, tens, hundreds, thousands, ten-thousands
  // ----------------------------------------------------------------------
  wire [16:0] pd = output_polarity_digits_r;
  wire neg_sw = (pd % 17'd10) != 17'd0;
  wire neg_c1 = ((pd / 17'd10) % 17'd10) != 17'd0;
  wire neg_c2 = ((pd / 17'd100) % 17'd10) != 17'd0;
  wire neg_s2 = ((pd / 17'd1000) % 17'd10) != 17'd0;
  wire neg_do = ((pd / 17'd10000) % 17'd10) != 17'd0;
  // ----------------------------------------------------------------------
  // full-scale references for the source mapping
  // ----------------------------------------------------------------------
  wire [Q_W+3:0] ref_max = {4'h0, i_max_freq};
  wire [Q_W+3:0] ref_cur = {3'b000, i_rated_current, 1'b0};
  wire [Q_W+3:0] ref_trq = {3'b000, i_rated_torque, 1'b0};
  wire [Q_W+3:0] ref_pwr = {3'b000, i_rated_power, 1'b0};
  // 1.2 x rated voltage, truncated
  wire [Q_W+3:0] ref_vlt = ({4'h0, i_rated_voltage} * 5'd12) / 5'd10;
  // ----------------------------------------------------------------------
  // analog channels, registered two stages
  // ----------------------------------------------------------------------
  reg [15:0] std_one_r; // standard output, channel one
  reg [15:0] std_two_r; // standard output, channel two
  reg [15:0] std_pulse_r; // pulse source 0..1000
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      std_one_r <= 16'h0000;
      std_two_r <= 16'h0000;
      std_pulse_r <= 16'h0000;
      o_analog_out_one <= 10'h000;
      o_analog_out_two <= 10'h000;
    end else begin
      std_one_r <= otc_src(analog_one_source_select_r, ref_max, ref_cur,
        ref_trq, ref_pwr, ref_vlt);
      std_two_r <= otc_src(analog_two_source_select_r, ref_max, ref_cur,
        ref_trq, ref_pwr, ref_vlt);
      std_pulse_r <= otc_src(pulse_source_select_r, ref_max, ref_cur,
        ref_trq, ref_pwr, ref_vlt);
      o_analog_out_one <= otc_adjust(std_one_r, analog_one_gain_r,
        analog_one_zero_offset_r);
      o_analog_out_two <= otc_adjust(std_two_r, analog_two_gain_r,
        analog_two_zero_offset_r);
    end
  end
  // ----------------------------------------------------------------------
  // pulse frequency: 1 + (fs - 1) * pct / 1000 in 0.01 khz units
  // step = f * 10 hz * 2^32 / clk; f <= 10000 keeps it in 32 bits
  // ----------------------------------------------------------------------
  reg [13:0] pulse_freq_r; // current pulse frequency
  reg [31:0] step_r; // nco phase step
  wire [29:0] span = ({16'h0000, pulse_full_scale_freq_r} - 30'd1)
    * {14'h0000, std_pulse_r};
  // divide before cutting: the product alone overflows 14 bits
  wire [29:0] span_q = span / 30'd1000;
  wire [63:0] step_wide = {50'h0, pulse_freq_r} * 64'd42949672960
    / 64'd250000000;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pulse_freq_r <= 14'h0001;
      step_r <= 32'h00000000;
    end else begin
      pulse_freq_r <= 14'h0001 + span_q[13:0];
      step_r <= step_wide[31:0];
    end
  end
  wire nco_out; // raw pulse train
  otc_nco #(.ACC_W(32)) u_nco (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_step(step_r),
    .o_pulse(nco_out)
  );
  // ----------------------------------------------------------------------
  // 0.1 s tick and synchronised status
  // ----------------------------------------------------------------------
  reg [TICK_W-1:0] tick_cnt_r; // divider for 0.1 s
  reg tick_r; // 0.1 s pulse
  reg [4:0] st_s1_r; // first sync stage
  reg [4:0] st_s2_r; // second sync stage
  reg mode_s1_r; // pulse mode sync first stage
  reg mode_s2_r; // pulse mode sync second stage
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_r <= {TICK_W{1'b0}};
      tick_r <= 1'b0;
      st_s1_r <= 5'h00;
      st_s2_r <= 5'h00;
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
    end else begin
      st_s1_r <= i_func_status;
      st_s2_r <= st_s1_r;
      mode_s1_r <= i_pulse_mode;
      mode_s2_r <= mode_s1_r;
      tick_r <= (tick_cnt_r == TICK_CYC - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ?
        {TICK_W{1'b0}} : tick_cnt_r + 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // switched terminals
  // ----------------------------------------------------------------------
  wire [4:0] close_w; // delayed (bits 0..3), polarity-applied states
  wire [3:0] neg_w = {neg_s2, neg_c2, neg_c1, neg_sw};
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sw
      otc_delay_out #(.CNT_W(16)) u_dly (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_tick(tick_r),
        .i_status(st_s2_r[g]),
        .i_delay(delay_r[g]),
        .i_negative(neg_w[g]),
        .o_close(close_w[g])
      );
    end
  endgenerate
  // digital output has no delay setting; polarity only
  assign close_w[4] = st_s2_r[4] ^ neg_do;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pulse_capable_output <= 1'b0;
      o_contact_output_one <= 1'b0;
      o_contact_output_two <= 1'b0;
      o_second_switch_output <= 1'b0;
      o_digital_output <= 1'b0;
    end else begin
      o_pulse_capable_output <= mode_s2_r ? nco_out : close_w[0];
      o_contact_output_one <= close_w[1];
      o_contact_output_two <= close_w[2];
      o_second_switch_output <= close_w[3];
      o_digital_output <= close_w[4];
    end
  end
endmodule // otc_top

// >>> testbench/otc_load_model.sv
// external loads on the switched terminals, with a pulse edge counter
`timescale 1ns/1ns
module otc_load_model (
  input wire logic i_ref_clk, // system clock
  input wire logic i_pulse_term, // pulse_capable_output terminal
  input wire logic [3:0] i_contacts, // closed-to-return terminals
  output logic [3:0] o_energised, // load conducting
  output int o_edges // rising edges seen on the pulse terminal
);
  logic last_r = 1'b0; // previous pulse terminal level
  initial o_edges = 0;
  // a load only conducts while its terminal is closed to common_return
  always @(posedge i_ref_clk) begin
    o_energised <= i_contacts;
    last_r <= i_pulse_term;
    if (i_pulse_term && !last_r) begin
      o_edges <= o_edges + 1;
    end
  end
endmodule // otc_load_model

// >>> testbench/otc_top_properties.sv
// concurrent checks on the conditioner's bus and terminal outputs
`timescale 1ns/1ns
module otc_top_properties (
  input wire i_ref_clk, // system clock
  input wire i_resetn, // async reset, active low
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire [4:0] i_func_status, // function states
  input wire [31:0] o_prdata, // apb read data
  input wire o_pready, // apb ready
  input wire o_pslverr, // apb error
  input wire o_contact_output_one, // relay one closed
  input wire o_digital_output, // digital output closed
  input wire [9:0] o_analog_out_one, // channel one value
  input wire [9:0] o_analog_out_two // channel two value
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // an access taken by the slave, and seven cycles with no select and status bit 4 stable
  sequence taken_s; i_psel && i_penable && !o_pready; endsequence
  sequence quiet_s; (!i_psel && $stable(i_func_status[4]))[*7]; endsequence
  chk_ready_wait: assert property (taken_s |=> o_pready)
    else $error("ready missing after taken access");
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  chk_error_pair: assert property (o_pslverr |-> o_pready && o_prdata == 0)
    else $error("error without ready or with data");
  chk_data_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside ready cycle");
  chk_ao1_range: assert property (o_analog_out_one <= 10'h3e8)
    else $error("channel one above full scale");
  chk_ao2_range: assert property (o_analog_out_two <= 10'h3e8)
    else $error("channel two above full scale");
  chk_digital_hold: assert property (quiet_s |-> $stable(o_digital_output))
    else $error("digital output moved with steady status");
  chk_reset_quiet: assert property ($rose(i_resetn) |->
    !o_contact_output_one && !o_digital_output && o_analog_out_one == 0)
    else $error("outputs active right after reset");
endmodule // otc_top_properties
bind otc_top otc_top_properties u_chk (.*);

// >>> testbench/testbench.sv
// self-checking bench for the output terminal conditioner
`timescale 1ns/1ns
`include "otc_defines.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  n_fail++; $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, i_pulse_mode = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rd_v;
  logic [15:0] i_run_freq = 16'h0, i_set_freq = 16'h0, i_current = 16'h0;
  logic [15:0] i_torque = 16'h0, i_power = 16'h0, i_voltage = 16'h0;
  logic [15:0] i_other_pct = 16'h0, i_max_freq = 16'h03e8;
  logic [15:0] i_rated_current = 16'h0064, i_rated_torque = 16'h0064;
  logic [15:0] i_rated_power = 16'h0064, i_rated_voltage = 16'h0064;
  logic [4:0] i_func_status = 5'h00;
  logic err_v;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_pulse_capable_output, o_contact_output_one;
  wire o_contact_output_two, o_second_switch_output, o_digital_output;
  wire [9:0] o_analog_out_one, o_analog_out_two;
  wire [3:0] lit;
  int edges, e0, n_fail = 0, total_checks = 0, cyc = 0;
  // short delay tick so delays fit in the run
  otc_top #(.TICK_CYC(10)) dut (.*);
  otc_load_model load (.i_ref_clk(i_ref_clk),
    .i_pulse_term(o_pulse_capable_output), .o_energised(lit), .o_edges(edges),
    .i_contacts({o_digital_output, o_second_switch_output,
      o_contact_output_two, o_contact_output_one}));
  always #2 i_ref_clk = ~i_ref_clk;
  // hang guard: the tests need about 25300 cycles
  always @(posedge i_ref_clk) if (++cyc == 60000) begin
    n_fail++;
    complete_run();
  end
  // one apb transfer, held until ready is sampled high
  task automatic apb(input [7:0] a, input w, input [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_paddr <= a;
    i_pwrite <= w;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    rd_v = o_prdata;
    err_v = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d); apb(a, 1'b1, d); endtask
  task automatic wt(input int n); repeat (n) @(posedge i_ref_clk); endtask
  task automatic t_regs;
    apb(`OTC_ADDR_PULSE_FS, 1'b0, 32'h0);
    `CHK("full scale", 32'h1388, rd_v)
    apb(`OTC_ADDR_AO1_GAIN, 1'b0, 32'h0);
    `CHK("gain", 32'h64, rd_v)
    apb(`OTC_ADDR_AO2_OFS, 1'b0, 32'h0);
    `CHK("offset", 32'h0, rd_v)
    apb(8'h40, 1'b0, 32'h0);
    `CHK("unmapped", 1'b1, err_v)
    $display("test regs done");
  endtask
  task automatic t_analog;
    wr(`OTC_ADDR_AO1_SRC, 32'h2);
    i_current <= 16'h0064;
    i_set_freq <= 16'h01f4;
    wt(6);
    `CHK("current", 10'h1f4, o_analog_out_one)
    `CHK("set freq", 10'h1f4, o_analog_out_two)
    wr(`OTC_ADDR_AO2_SRC, 32'h3);
    wr(`OTC_ADDR_AO1_SRC, 32'h5);
    i_torque <= 16'h0032;
    i_voltage <= 16'h003c;
    wt(6);
    `CHK("torque", 10'h0fa, o_analog_out_two)
    `CHK("voltage", 10'h1f4, o_analog_out_one)
    wr(`OTC_ADDR_AO1_SRC, 32'h0);
    wr(`OTC_ADDR_AO1_GAIN, 32'hffce);
    wr(`OTC_ADDR_AO1_OFS, 32'h320);
    wt(6);
    `CHK("offset only", 10'h320, o_analog_out_one)
    i_run_freq <= 16'h03e8;
    wt(6);
    apb(`OTC_ADDR_AO1_VAL, 1'b0, 32'h0);
    `CHK("gain offset", 32'h12c, rd_v)
    wr(`OTC_ADDR_AO1_GAIN, 32'hc8);
    wt(6);
    `CHK("clamp high", 10'h3e8, o_analog_out_one)
    wr(`OTC_ADDR_AO2_SRC, 32'h4);
    i_power <= 16'h0064;
    wt(6);
    `CHK("power", 10'h1f4, o_analog_out_two)
    wr(`OTC_ADDR_AO2_SRC, 32'h6);
    i_other_pct <= 16'h07d0;
    wt(6);
    `CHK("other clamp", 10'h3e8, o_analog_out_two)
    $display("test analog done");
  endtask
  task automatic t_switch;
    wr(`OTC_ADDR_DLY_C1, 32'h3);
    i_func_status <= 5'h12;
    wt(8);
    `CHK("relay early", 1'b0, o_contact_output_one)
    `CHK("digital", 1'b1, o_digital_output)
    wt(40);
    `CHK("relay late", 1'b1, lit[0])
    wr(`OTC_ADDR_POLARITY, 32'ha);
    wt(40);
    `CHK("relay inverted", 1'b0, o_contact_output_one)
    wr(`OTC_ADDR_POLARITY, 32'h186a0);
    apb(`OTC_ADDR_POLARITY, 1'b0, 32'h0);
    `CHK("polarity kept", 32'ha, rd_v)
    i_func_status <= 5'h1f;
    wt(12);
    `CHK("other terms", 4'hf, {lit[3:1], o_pulse_capable_output})
    $display("test switch done");
  endtask
  task automatic t_pulse;
    wr(`OTC_ADDR_PULSE_FS, 32'h2710);
    i_pulse_mode <= 1'b1;
    wt(100);
    e0 = edges;
    wt(25000);
    `CHK("pulse edges", 1'b1, (edges - e0 >= 9 && edges - e0 <= 11))
    $display("test pulse done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    wt(4);
    i_resetn <= 1'b1;
    wt(2);
    t_regs();
    t_analog();
    t_switch();
    t_pulse();
    complete_run();
  end
endmodule // testbench
